//--- src/rbas_pkg.sv
// constants, bit classes and register layout of the management bit bank
package rbas_pkg;

  localparam int NREG = 4;
  localparam int DW   = 16;
  localparam int IDXW = 2;

  typedef enum logic [3:0] {
    CLS_RW, CLS_RO, CLS_WO, CLS_W1C, CLS_WRITE_ANY_CLEAR,
    CLS_RW_WRITE_ANY_CLEAR, CLS_RC, CLS_LATCH_LOW, CLS_LATCH_HIGH,
    CLS_RO_LATCH_HIGH, CLS_SELF_CLEARING, CLS_SELF_SETTING, CLS_RSV
  } rbas_cls_t;

  // register indices
  localparam logic [IDXW-1:0] IDX_CTL = 2'h0;
  localparam logic [IDXW-1:0] IDX_STS = 2'h1;
  localparam logic [IDXW-1:0] IDX_EVT = 2'h2;
  localparam logic [IDXW-1:0] IDX_CNT = 2'h3;

  // control register fields
  localparam int CTL_SRST   = 15;
  localparam int CTL_RW_HI  = 14;
  localparam int CTL_RW_LO  = 12;
  localparam int CTL_IMM    = 11;
  localparam int CTL_ACT    = 10;
  localparam int CTL_WO     = 9;
  localparam int CTL_RSV_HI = 6;

  // status register fields
  localparam int STS_RO_LO     = 8;
  localparam int STS_RSV_LO    = 6;
  localparam int STS_RO_LATCH  = 5;
  localparam int STS_LATCH_HI  = 4;
  localparam int STS_RO        = 3;
  localparam int STS_LATCH_LO  = 2;
  localparam int STS_RWAC      = 1;
  localparam int STS_SELF_SET  = 0;

  // event register fields
  localparam int EVT_W1C_LO = 8;
  localparam int EVT_WAC    = 0;

  // soft reset timing
  localparam real SRST_MAX_S       = 0.5;
  localparam int  CLK_HZ           = 25_000_000;
  localparam int  SRST_MAX_CYC_DEF = int'($floor(SRST_MAX_S * CLK_HZ));
  localparam int  SRST_SETTLE_CYC  = 4;
  localparam int  SRST_CW          = 3;
  localparam int  SRST_AGE_W       = 24;

  function automatic rbas_cls_t cls_of(input int r, input int b);
    rbas_cls_t c;
    c = CLS_RC;
    case (r)
      int'(IDX_CTL): begin
        if (b == CTL_SRST || b == CTL_ACT) c = CLS_SELF_CLEARING;
        else if (b == CTL_WO) c = CLS_WO;
        else if (b <= CTL_RSV_HI) c = CLS_RSV;
        else c = CLS_RW;
      end
      int'(IDX_STS): begin
        if (b >= STS_RO_LO) c = CLS_RO;
        else if (b >= STS_RSV_LO) c = CLS_RSV;
        else if (b == STS_RO_LATCH) c = CLS_RO_LATCH_HIGH;
        else if (b == STS_LATCH_HI) c = CLS_LATCH_HIGH;
        else if (b == STS_RO) c = CLS_RO;
        else if (b == STS_LATCH_LO) c = CLS_LATCH_LOW;
        else if (b == STS_RWAC) c = CLS_RW_WRITE_ANY_CLEAR;
        else c = CLS_SELF_SETTING;
      end
      int'(IDX_EVT): begin
        c = (b >= EVT_W1C_LO) ? CLS_W1C : CLS_WRITE_ANY_CLEAR;
      end
      default: c = CLS_RC;
    endcase
    return c;
  endfunction : cls_of

  function automatic logic [DW-1:0] rst_val(input int r);
    logic [DW-1:0] v;
    v = 16'h0000;
    for (int b = 0; b < DW; b++) v[b] = (cls_of(r, b) == CLS_SELF_SETTING);
    return v;
  endfunction : rst_val

  // bits kept through a software reset (soft_reset_immune)
  function automatic logic [DW-1:0] imm_mask(input int r);
    logic [DW-1:0] v;
    v = 16'h0000;
    if (r == int'(IDX_CTL)) v[CTL_IMM] = 1'b1;
    return v;
  endfunction : imm_mask

  // write-only and reserved bits read as zero
  function automatic logic [DW-1:0] rd_mask(input int r);
    logic [DW-1:0] v;
    v = 16'h0000;
    for (int b = 0; b < DW; b++)
      v[b] = !(cls_of(r, b) inside {CLS_WO, CLS_RSV});
    return v;
  endfunction : rd_mask

endpackage : rbas_pkg

//--- src/rbas_srst_if.sv
// soft reset request and clear strobe between bank and sequencer
`timescale 1ns/10ps
interface rbas_srst_if;
  logic req;
  logic clr;
  logic busy;
  modport seq  (input req, output clr, output busy);
  modport bank (output req, input clr, input busy);
endinterface : rbas_srst_if

//--- src/rbas_srst_seq.sv
// soft reset sequencer: settles, then issues one clear strobe
`timescale 1ns/10ps
module rbas_srst_seq import rbas_pkg::*; (
  input  wire logic clk,  // device clock
  input  wire logic ce,   // clock enable
  input  wire logic nrst, // sync reset, active low
  rbas_srst_if.seq  s     // request in, clear out
);
  logic               busy_ff;
  logic               clr_ff;
  logic [SRST_CW-1:0] cnt_ff;

  localparam logic [SRST_CW-1:0] SETTLE_LAST = SRST_CW'(SRST_SETTLE_CYC - 1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
    end else if (ce) begin
      if (clr_ff) busy_ff <= 1'b0;
      else if (s.req) busy_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (busy_ff && !clr_ff) cnt_ff <= cnt_ff + SRST_CW'(1);
      else cnt_ff <= '0;
    end
  end

  // one strobe per request; the bank drops req with that same strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clr_ff <= 1'b0;
    end else if (ce) begin
      clr_ff <= busy_ff && !clr_ff && (cnt_ff == SETTLE_LAST);
    end
  end

  assign s.clr  = clr_ff;
  assign s.busy = busy_ff;

endmodule : rbas_srst_seq

//--- src/rbas_reg_bank.sv
// management register bank applying per-bit access classes
// Notes on behaviour
// RL1 - read-only bits ignore writes; reads show the current value
// RL2 - write-only bits take writes; reads return nothing meaningful
// RL3 - write-one-to-clear: a one clears the bit, a zero leaves it
// RL4 - write_any_clear: any write to the register clears the bit
// RL5 - read-to-clear: read returns content, clears after, writes ignored
// RL6 - latch_low bit is released by reading its register
// RL7 - latch_high bit is released by reading its register
// RL8 - self_clearing bit set by one, drops after its action; zero ignored
// RL9 - self-setting bit cleared by zero, returns to one; one ignored
// RL10 - read_only_latch_high bit sets on condition, holds until read
// RL11 - after the read it follows the condition still present
// RL12 - unread latched bit ignores changes of its condition
// RL13 - soft_reset_immune bits survive a software reset
// RL14 - host writes zero to reserved bits
// RL15 - host does not trust reserved bits on read
// RL16 - read-write bit stores the write and reads back the setting
// RL17 - read plus write_any_clear: reads value, any write clears
// RL18 - software reset returns all non-immune bits to their reset values within half a second
// RL19 - latch_low bit drops on failure, holds until read, then follows
`timescale 1ns/10ps
module rbas_reg_bank import rbas_pkg::*; #(
  parameter int SRST_MAX_CYC = SRST_MAX_CYC_DEF // soft reset deadline
) (
  input  wire logic            clk,        // device clock, 25 MHz
  input  wire logic            ce,         // clock enable, freezes all
  input  wire logic            nrst,       // sync reset, active low
  input  wire logic            acc_rd,     // read strobe
  input  wire logic            acc_wr,     // write strobe
  input  wire logic [IDXW-1:0] acc_idx,    // register index
  input  wire logic [DW-1:0]   acc_wdata,  // write data
  output logic      [DW-1:0]   acc_rdata,  // read data, registered
  output logic                 acc_rvalid, // read data valid pulse
  input  wire logic [DW-1:0]   hw_sts,     // live status conditions
  input  wire logic [DW-1:0]   hw_evt,     // event set pulses
  input  wire logic [DW-1:0]   hw_cnt,     // read-clear set pulses
  output logic      [DW-1:0]   ctl_q,      // control register value
  output logic                 act_pulse,  // self-clearing action
  output logic                 srst_busy   // soft reset in progress
);
  logic [DW-1:0] reg_ff [NREG];
  logic [DW-1:0] nxt_reg [NREG];
  logic [DW-1:0] cond [NREG];
  logic [DW-1:0] rdata_ff;
  logic          rvalid_ff;
  logic          rd_ok;
  logic          wr_ok;

  rbas_srst_if srst ();

  rbas_srst_seq u_seq (
    .clk  (clk),
    .ce   (ce),
    .nrst (nrst),
    .s    (srst.seq)
  );

  // a read and a write in one cycle is refused as a whole
  assign rd_ok = acc_rd && !acc_wr;
  assign wr_ok = acc_wr && !acc_rd;

  assign cond[IDX_CTL] = 16'h0000;
  assign cond[IDX_STS] = hw_sts;
  assign cond[IDX_EVT] = hw_evt;
  assign cond[IDX_CNT] = hw_cnt;

  assign srst.req = reg_ff[IDX_CTL][CTL_SRST];

  // next value of one bit; hardware set beats a read or write clear
  function automatic logic bit_nxt(
    input rbas_cls_t c,
    input logic      q,
    input logic      rd,
    input logic      wr,
    input logic      wd,
    input logic      hw,
    input logic      hold
  );
    logic n;
    n = q;
    unique case (c)
      CLS_RW:                 n = wr ? wd : q;         // RL16
      CLS_RO:                 n = hw;                  // RL1
      CLS_WO:                 n = wr ? wd : q;         // RL2
      CLS_W1C:                n = hw | (q & ~(wr & wd)); // RL3
      CLS_WRITE_ANY_CLEAR:    n = hw | (q & ~wr);      // RL4
      CLS_RW_WRITE_ANY_CLEAR: n = hw | (q & ~wr);      // RL17
      CLS_RC:                 n = hw | (q & ~rd);      // RL5
      CLS_LATCH_LOW:          n = hw & (q | rd);       // RL6 RL19
      CLS_LATCH_HIGH:         n = hw | (q & ~rd);      // RL7
      CLS_RO_LATCH_HIGH:      n = hw | (q & ~rd);      // RL10 RL11 RL12
      CLS_SELF_CLEARING:      n = (wr & wd) | (q & hold); // RL8
      CLS_SELF_SETTING:       n = ~(wr & ~wd);         // RL9
      CLS_RSV:                n = 1'b0;                // RL14
      default:                n = 1'b0;
    endcase
    return n;
  endfunction : bit_nxt

  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      for (int b = 0; b < DW; b++) begin
        nxt_reg[r][b] = bit_nxt(cls_of(r, b), reg_ff[r][b],
                                rd_ok && (acc_idx == IDXW'(r)),
                                wr_ok && (acc_idx == IDXW'(r)),
                                acc_wdata[b], cond[r][b],
                                (r == int'(IDX_CTL)) && (b == CTL_SRST));
      end
      // soft reset keeps immune bits, reloads the rest
      if (srst.clr) begin
        nxt_reg[r] = (reg_ff[r] & imm_mask(r))
                   | (rst_val(r) & ~imm_mask(r)); // RL13 RL18
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int r = 0; r < NREG; r++) reg_ff[r] <= rst_val(r);
    end else if (ce) begin
      for (int r = 0; r < NREG; r++) reg_ff[r] <= nxt_reg[r];
    end
  end

  // read captures the pre-clear content in the edge that clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= 16'h0000;
    end else if (ce && rd_ok) begin
      rdata_ff <= reg_ff[acc_idx] & rd_mask(int'(acc_idx)); // RL5 RL15
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rvalid_ff <= rd_ok;
    end
  end

  assign acc_rdata  = rdata_ff;
  assign acc_rvalid = rvalid_ff;
  assign ctl_q      = reg_ff[IDX_CTL];
  assign act_pulse  = reg_ff[IDX_CTL][CTL_ACT];
  assign srst_busy  = srst.busy;

  // ---- checks ----
  logic                  quiet;
  logic                  wr_ctl;
  logic                  wr_sts;
  logic                  wr_evt;
  logic                  wr_cnt;
  logic                  rd_sts;
  logic                  rd_cnt;
  logic                  rd_ctl;
  logic [SRST_AGE_W-1:0] srst_age_ff;

  assign quiet  = ce && !srst.clr;
  assign wr_ctl = wr_ok && (acc_idx == IDX_CTL);
  assign wr_sts = wr_ok && (acc_idx == IDX_STS);
  assign wr_evt = wr_ok && (acc_idx == IDX_EVT);
  assign wr_cnt = wr_ok && (acc_idx == IDX_CNT);
  assign rd_sts = rd_ok && (acc_idx == IDX_STS);
  assign rd_cnt = rd_ok && (acc_idx == IDX_CNT);
  assign rd_ctl = rd_ok && (acc_idx == IDX_CTL);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      srst_age_ff <= '0;
    end else if (ce) begin
      srst_age_ff <= srst.req ? srst_age_ff + SRST_AGE_W'(1) : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_no_sts_read;
    quiet && !rd_sts;
  endsequence

  sequence s_ll_fail;
    quiet && !hw_sts[STS_LATCH_LO] && !rd_sts;
  endsequence

  sequence s_lh_set;
    quiet && hw_sts[STS_LATCH_HI];
  endsequence

  sequence s_act_once;
    wr_ctl && quiet && acc_wdata[CTL_ACT]
    ##1 quiet && !(wr_ctl && acc_wdata[CTL_ACT]);
  endsequence

  sequence s_ss_clear;
    wr_sts && quiet && !acc_wdata[STS_SELF_SET]
    ##1 quiet && !(wr_sts && !acc_wdata[STS_SELF_SET]);
  endsequence

  property p_ro_ignores_wr;
    wr_sts && quiet |=>
      reg_ff[IDX_STS][DW-1:STS_RO_LO] == $past(hw_sts[DW-1:STS_RO_LO]);
  endproperty
  a_ro_ignores_wr: assert property (p_ro_ignores_wr) // RL1
    else $error("read-only bits took a write");

  property p_wo_reads_zero;
    rd_ctl && ce |=> acc_rvalid && !acc_rdata[CTL_WO]
                     && acc_rdata[CTL_RSV_HI:0] == '0;
  endproperty
  a_wo_reads_zero: assert property (p_wo_reads_zero) // RL2
    else $error("write-only or reserved bit read nonzero");

  property p_w1c;
    wr_evt && quiet && !hw_evt[EVT_W1C_LO] |=>
      reg_ff[IDX_EVT][EVT_W1C_LO] ==
      ($past(reg_ff[IDX_EVT][EVT_W1C_LO]) && !$past(acc_wdata[EVT_W1C_LO]));
  endproperty
  a_w1c: assert property (p_w1c) // RL3
    else $error("write-one-to-clear bit wrong after write");

  property p_wac;
    wr_evt && quiet && !hw_evt[EVT_WAC] |=> !reg_ff[IDX_EVT][EVT_WAC];
  endproperty
  a_wac: assert property (p_wac) // RL4
    else $error("write-any-clear bit survived a write");

  property p_rc_read;
    rd_cnt && quiet && reg_ff[IDX_CNT][0] && !hw_cnt[0] |=>
      acc_rdata[0] && !reg_ff[IDX_CNT][0];
  endproperty
  a_rc_read: assert property (p_rc_read) // RL5
    else $error("read-clear bit not returned then cleared");

  property p_rc_write;
    wr_cnt && quiet |=> reg_ff[IDX_CNT] == $past(reg_ff[IDX_CNT] | hw_cnt);
  endproperty
  a_rc_write: assert property (p_rc_write) // RL5
    else $error("read-clear register changed by a write");

  property p_ll_hold;
    s_ll_fail ##1 s_no_sts_read [*2] |=> !reg_ff[IDX_STS][STS_LATCH_LO];
  endproperty
  a_ll_hold: assert property (p_ll_hold) // RL19
    else $error("latch-low bit recovered before a read");

  property p_ll_read;
    rd_sts && quiet |=>
      reg_ff[IDX_STS][STS_LATCH_LO] == $past(hw_sts[STS_LATCH_LO]);
  endproperty
  a_ll_read: assert property (p_ll_read) // RL6
    else $error("latch-low bit not released by read");

  property p_lh_hold;
    s_lh_set ##1 s_no_sts_read [*3] |=> reg_ff[IDX_STS][STS_LATCH_HI];
  endproperty
  a_lh_hold: assert property (p_lh_hold) // RL10 RL12
    else $error("latch-high bit dropped before a read");

  property p_lh_read;
    rd_sts && quiet |=>
      reg_ff[IDX_STS][STS_LATCH_HI] == $past(hw_sts[STS_LATCH_HI])
      && reg_ff[IDX_STS][STS_RO_LATCH] == $past(hw_sts[STS_RO_LATCH]);
  endproperty
  a_lh_read: assert property (p_lh_read) // RL7 RL11
    else $error("latch-high bit wrong after read");

  property p_sc;
    s_act_once |-> act_pulse ##1 !act_pulse;
  endproperty
  a_sc: assert property (p_sc) // RL8
    else $error("self-clearing bit did not pulse once");

  property p_ss;
    s_ss_clear |-> !reg_ff[IDX_STS][STS_SELF_SET]
                   ##1 reg_ff[IDX_STS][STS_SELF_SET];
  endproperty
  a_ss: assert property (p_ss) // RL9
    else $error("self-setting bit did not return to one");

  property p_rw;
    wr_ctl && quiet |=> ctl_q[CTL_RW_HI:CTL_RW_LO] ==
                        $past(acc_wdata[CTL_RW_HI:CTL_RW_LO]);
  endproperty
  a_rw: assert property (p_rw) // RL16
    else $error("read-write bits did not store the write");

  property p_rwac;
    wr_sts && quiet && !hw_sts[STS_RWAC] |=> !reg_ff[IDX_STS][STS_RWAC];
  endproperty
  a_rwac: assert property (p_rwac) // RL17
    else $error("read plus write-any-clear bit survived a write");

  property p_srst_clear;
    srst.clr && ce |=> ctl_q[CTL_IMM] == $past(ctl_q[CTL_IMM])
                       && !ctl_q[CTL_SRST] && reg_ff[IDX_EVT] == '0;
  endproperty
  a_srst_clear: assert property (p_srst_clear) // RL13 RL18
    else $error("soft reset cleared an immune bit or missed one");

  property p_srst_deadline;
    srst_age_ff < SRST_MAX_CYC;
  endproperty
  a_srst_deadline: assert property (p_srst_deadline) // RL18
    else $error("soft reset overran its deadline");

endmodule : rbas_reg_bank

//--- sim/rbas_host_model.sv
// management host model: drives single-cycle register accesses
`timescale 1ns/10ps
module rbas_host_model import rbas_pkg::*; (
  input  wire logic            clk,      // device clock
  output logic                 ce,       // clock enable
  output logic                 acc_rd,   // read strobe
  output logic                 acc_wr,   // write strobe
  output logic      [IDXW-1:0] acc_idx,  // register index
  output logic      [DW-1:0]   acc_wdata // write data
);
  initial begin
    ce        = 1'b1;
    acc_rd    = 1'b0;
    acc_wr    = 1'b0;
    acc_idx   = IDX_CTL;
    acc_wdata = 16'h0000;
  end

  // reserved positions are always written as zero
  function automatic logic [DW-1:0] wmask(input logic [IDXW-1:0] i);
    wmask = 16'hFFFF;
    if (i == IDX_CTL) wmask = 16'hFF80;
    if (i == IDX_STS) wmask = 16'hFF3F;
  endfunction : wmask

  // read-back positions the host may rely on
  function automatic logic [DW-1:0] care(input logic [IDXW-1:0] i);
    care = wmask(i);
    if (i == IDX_CTL) care = 16'hFD80;
  endfunction : care

  task automatic access(input logic rd, input logic [IDXW-1:0] i,
                        input logic [DW-1:0] d, input logic en);
    @(negedge clk);
    ce        = en;
    acc_rd    = rd;
    acc_wr    = !rd;
    acc_idx   = i;
    acc_wdata = d & wmask(i);
    @(negedge clk);
    ce        = 1'b1;
    acc_rd    = 1'b0;
    acc_wr    = 1'b0;
    // released data does not keep its last value
    acc_wdata = ~acc_wdata;
  endtask : access
endmodule : rbas_host_model

//--- sim/tb_top.sv
// self-checking bench for the management bit bank
`timescale 1ns/10ps
module tb_top import rbas_pkg::*; ();
  typedef struct {
    logic [DW-1:0] val;
    logic [DW-1:0] msk;
  } rbas_exp_t;

  localparam int SRST_CYC = 64;
  logic            clk;
  logic            nrst;
  logic            ce;
  logic            acc_rd;
  logic            acc_wr;
  logic [IDXW-1:0] acc_idx;
  logic [DW-1:0]   acc_wdata;
  logic [DW-1:0]   acc_rdata;
  logic            acc_rvalid;
  logic [DW-1:0]   hw_sts;
  logic [DW-1:0]   hw_evt;
  logic [DW-1:0]   hw_cnt;
  logic [DW-1:0]   ctl_q;
  logic            act_pulse;
  logic            srst_busy;
  logic [DW-1:0]   hs;
  logic [DW-1:0]   base;
  logic [DW-1:0]   w;
  rbas_exp_t       exp_q[$];
  int              fails;
  int              compares;
  int              cyc = 0;
  int              n;

  rbas_host_model host (.clk(clk), .ce(ce), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_idx(acc_idx), .acc_wdata(acc_wdata));

  rbas_reg_bank #(.SRST_MAX_CYC(SRST_CYC)) uut (.clk(clk), .ce(ce),
    .nrst(nrst), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_idx(acc_idx),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .hw_sts(hw_sts), .hw_evt(hw_evt),
    .hw_cnt(hw_cnt), .ctl_q(ctl_q), .act_pulse(act_pulse),
    .srst_busy(srst_busy));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [DW-1:0] e,
                     input logic [DW-1:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rd(input rbas_exp_t e, input logic [DW-1:0] g);
    chk("read data", e.val & e.msk, g & e.msk);
  endtask : chk_rd

  task automatic wr(input logic [IDXW-1:0] i, input logic [DW-1:0] d);
    host.access(1'b0, i, d, 1'b1);
  endtask : wr

  // the note is queued before the request goes out
  task automatic rd(input logic [IDXW-1:0] i, input logic [DW-1:0] v,
                    input logic [DW-1:0] m = 16'hFFFF);
    rbas_exp_t e;
    e.val = v;
    e.msk = m & host.care(i);
    exp_q.push_back(e);
    host.access(1'b1, i, 16'h0000, 1'b1);
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask : idle

  task automatic pulse_sts(input logic [DW-1:0] v);
    @(negedge clk);
    hw_sts = v;
    @(negedge clk);
    hw_sts = hs;
    idle(3);
  endtask : pulse_sts

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  always @(negedge clk) begin
    if (acc_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected read", 16'h0000, 16'h0001);
      else chk_rd(exp_q.pop_front(), acc_rdata);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    fails = 0;
    compares = 0;
    nrst = 1'b0;
    hw_evt = 16'h0000;
    hw_cnt = 16'h0000;
    void'($urandom(32'hccfb));
    // bit2 condition held high so the latch_low bit has a cause
    hs = (16'($urandom()) & 16'hFF08) | 16'h0004;
    hw_sts = hs;
    base = hs | 16'h0001;
    idle(16);
    nrst = 1'b1;
    idle(3);
    rd(IDX_CTL, 16'h0000);
    rd(IDX_STS, base & 16'hFFFB);
    rd(IDX_EVT, 16'h0000);
    rd(IDX_CNT, 16'h0000);
    rd(IDX_STS, base);
    done("reset");
    w = 16'($urandom()) & 16'h7B80;
    wr(IDX_CTL, w | 16'h0400);
    n = 0;
    repeat (4) begin
      if (act_pulse === 1'b1) n++;
      @(negedge clk);
    end
    chk("act_pulse count", 16'h0001, n[DW-1:0]);
    chk("ctl_q", w & 16'h7980, ctl_q & 16'h7980);
    rd(IDX_CTL, w & 16'h7980);
    done("control");
    wr(IDX_STS, (~hs & 16'hFF08) | 16'h0001);
    rd(IDX_STS, base);
    wr(IDX_STS, 16'h0000);
    idle(2);
    rd(IDX_STS, base);
    done("status write");
    pulse_sts(hs & 16'hFFFB);
    rd(IDX_STS, base & 16'hFFFB);
    rd(IDX_STS, base);
    done("latch low");
    pulse_sts(hs | 16'h0030);
    rd(IDX_STS, base | 16'h0030);
    rd(IDX_STS, base);
    hw_sts = hs | 16'h0030;
    idle(3);
    rd(IDX_STS, base | 16'h0030);
    rd(IDX_STS, base | 16'h0030);
    hw_sts = hs;
    idle(3);
    // condition gone but unread: both latched bits must still stand
    rd(IDX_STS, base | 16'h0030);
    rd(IDX_STS, base);
    rd(IDX_STS, base);
    done("latch high");
    pulse_sts(hs | 16'h0002);
    rd(IDX_STS, base | 16'h0002);
    rd(IDX_STS, base | 16'h0002);
    wr(IDX_STS, 16'h0001);
    rd(IDX_STS, base);
    pulse_sts(hs | 16'h0002);
    done("write any clear status");
    @(negedge clk);
    hw_evt = 16'hFFFF;
    @(negedge clk);
    hw_evt = 16'h0000;
    idle(2);
    rd(IDX_EVT, 16'hFFFF);
    wr(IDX_EVT, 16'h0F00);
    rd(IDX_EVT, 16'hF000);
    done("event");
    w = 16'($urandom()) | 16'h0001;
    repeat (2) begin
      @(negedge clk);
      hw_cnt = w;
      @(negedge clk);
      hw_cnt = 16'h0000;
      idle(2);
      if (exp_q.size() == 0) begin
        wr(IDX_CNT, 16'hFFFF);
        rd(IDX_CNT, w);
        rd(IDX_CNT, 16'h0000);
      end
    end
    done("read clear");
    // a read with ce low must not release a pending latch
    pulse_sts(hs | 16'h0010);
    host.access(1'b1, IDX_STS, 16'h0000, 1'b0);
    idle(2);
    rd(IDX_STS, base | 16'h0012);
    rd(IDX_STS, base | 16'h0002);
    done("clock enable");
    wr(IDX_CTL, 16'hF980);
    n = 0;
    while (srst_busy !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("srst_busy rise", 16'h0001, {15'h0000, srst_busy});
    n = 0;
    while (srst_busy !== 1'b0 && n < SRST_CYC) begin
      @(negedge clk);
      n++;
    end
    chk("srst_busy fall", 16'h0000, {15'h0000, srst_busy});
    idle(2);
    chk("ctl_q", 16'h0800, ctl_q);
    rd(IDX_CTL, 16'h0800);
    rd(IDX_EVT, 16'h0000);
    rd(IDX_CNT, 16'h0000);
    rd(IDX_STS, base & 16'hFFFB);
    done("soft reset");
    idle(4);
    chk("pending reads", 16'h0000, 16'(exp_q.size()));
    give_verdict();
  end
endmodule : tb_top
